// [core/evd_exc_detect.sv]
// Exception condition detection, vector mapping and register slave
`timescale 1ns/1ps
`default_nettype none
module evd_exc_detect
    import evd_pkg::*;
(
    // Clock and reset
    input  wire logic              core_clk_i,
    input  wire logic              rst_i,
    // Completion stage
    input  wire evd_cmpl_t         cmpl_i,
    // Performance counters
    input  wire logic [31:0]       perf_counter_one_i,
    input  wire logic [31:0]       perf_counter_two_i,
    // Management interrupt, active low
    input  wire logic              system_mgmt_interrupt_n_i,
    // Avalon-MM slave
    input  wire logic [ADDR_W-1:0] avs_address_i,
    input  wire logic              avs_read_i,
    input  wire logic              avs_write_i,
    input  wire logic [31:0]       avs_writedata_i,
    input  wire logic [3:0]        avs_byteenable_i,
    output logic [31:0]            avs_readdata_o,
    output logic                   avs_waitrequest_o,
    // Exception request to the core
    output evd_exc_t               exc_o,
    // Interrupt
    output logic                   irq_o
);

    // Software-visible state
    logic [2:0]         machine_state_reg_ff;
    logic [1:0]         monitor_control_reg_zero_ff;
    logic [31:0]        instr_addr_breakpoint_reg_ff;
    logic [VEC_W-1:0]   last_vec_ff;
    logic [31:0]        taken_cnt_ff;

    // Detection state
    logic [N_CAUSE-1:0] pend_ff;
    logic               pmon_cond_ff;
    logic               smi_act_ff;
    evd_exc_t           exc_ff;

    // Bus state
    evd_bus_state_t     bus_ff;
    logic               waitreq_ff;
    logic [31:0]        rdata_ff;

    // Combinational
    logic               single_step_trace_enable;
    logic               branch_trace_enable;
    logic               external_interrupt_enable;
    logic               pmon_cond;
    logic               smi_act;
    logic               bp_hit;
    logic [N_CAUSE-1:0] ev;
    logic [N_CAUSE-1:0] elig;
    logic [N_CAUSE-1:0] take;
    logic [N_CAUSE-1:0] nxt_pend;
    logic               pick_valid;
    logic [VEC_W-1:0]   pick_vec;
    logic               req;
    logic               commit;
    logic               wr_commit;
    logic [N_CAUSE-1:0] status;
    logic [N_CAUSE-1:0] mask;
    logic               irq;
    logic [31:0]        nxt_rdata;
    logic [31:0]        wmerge_ms;
    logic [31:0]        wmerge_mc;
    logic [31:0]        wmerge_bp;
    logic [31:0]        wmerge_st;
    logic [31:0]        wmerge_mk;

    assign single_step_trace_enable  = machine_state_reg_ff[MS_SE];
    assign branch_trace_enable       = machine_state_reg_ff[MS_BE];
    assign external_interrupt_enable = machine_state_reg_ff[MS_EE];

    // Counter sign bit is the negative flag; each counter enabled alone
    assign pmon_cond =
        (monitor_control_reg_zero_ff[MC_EN_ONE] &&
         perf_counter_one_i[CNT_SIGN]) ||
        (monitor_control_reg_zero_ff[MC_EN_TWO] &&
         perf_counter_two_i[CNT_SIGN]);

    assign smi_act = !system_mgmt_interrupt_n_i;

    // Address field is the upper thirty bits; word index compare
    assign bp_hit = instr_addr_breakpoint_reg_ff[INSTR_ADDR_BREAKPOINT_REG_EN] &&
                    (instr_addr_breakpoint_reg_ff[31:INSTR_ADDR_BREAKPOINT_REG_LSB] ==
                     cmpl_i.addr[31:INSTR_ADDR_BREAKPOINT_REG_LSB]);

    // Raw events of this cycle
    always_comb
    begin
        ev = '0;
        ev[C_SYSC] = cmpl_i.valid && cmpl_i.syscall;
        ev[C_TRACE] = cmpl_i.valid &&
            ((single_step_trace_enable && cmpl_i.ok &&
              !cmpl_i.rfi) ||
             (branch_trace_enable && cmpl_i.branch));
        ev[C_INSTR_ADDR_BREAKPOINT_REG] = cmpl_i.valid && bp_hit;
        // Edge, so one negative crossing gives one exception
        ev[C_PMON] = pmon_cond && !pmon_cond_ff;
        ev[C_SMI]  = smi_act && !smi_act_ff;
    end

    // Asynchronous causes wait for the interrupt enable
    always_comb
    begin
        elig = pend_ff;
        elig[C_PMON] = pend_ff[C_PMON] &&
                       external_interrupt_enable;
        elig[C_SMI]  = pend_ff[C_SMI] && smi_act &&
                       external_interrupt_enable;
    end

    // Floating-point assist has no cause slot: never raised
    evd_prio_pick u_pick (
        .elig_i   (elig),
        .valid_o  (pick_valid),
        .onehot_o (take),
        .vector_o (pick_vec)
    );

    // New events beat the clear of the one being taken
    always_comb
    begin
        nxt_pend = (pend_ff & ~take) | ev;
        // Management request withdrawn before service is dropped
        if (!smi_act)
            nxt_pend[C_SMI] = 1'b0;
    end

    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
            pend_ff <= CAUSE_RST;
        else
            pend_ff <= nxt_pend;
    end

    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            pmon_cond_ff <= 1'b0;
            smi_act_ff   <= 1'b0;
        end
        else
        begin
            pmon_cond_ff <= pmon_cond;
            smi_act_ff   <= smi_act;
        end
    end

    // One exception request per cycle, registered
    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
            exc_ff <= '0;
        else
        begin
            exc_ff.valid  <= pick_valid;
            exc_ff.vector <= pick_valid ? pick_vec : '0;
            exc_ff.cause  <= take;
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
            last_vec_ff <= '0;
        else if (pick_valid)
            last_vec_ff <= pick_vec;
    end

    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
            taken_cnt_ff <= 32'h0000_0000;
        else if (pick_valid)
            taken_cnt_ff <= taken_cnt_ff + 32'h0000_0001;
    end

    // Bus handshake: one wait cycle, then one cycle of waitrequest low
    assign req       = avs_read_i || avs_write_i;
    assign commit    = (bus_ff == BUS_ACK) && req;
    assign wr_commit = commit && avs_write_i;

    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            bus_ff     <= BUS_IDLE;
            waitreq_ff <= 1'b1;
        end
        else
        begin
            unique case (bus_ff)
                BUS_IDLE:
                begin
                    if (req)
                    begin
                        bus_ff     <= BUS_ACK;
                        waitreq_ff <= 1'b0;
                    end
                end
                BUS_ACK:
                begin
                    bus_ff     <= BUS_IDLE;
                    waitreq_ff <= 1'b1;
                end
            endcase
        end
    end

    // Read data latched with the answer; unmapped reads give zero
    always_comb
    begin
        nxt_rdata = 32'h0000_0000;
        unique case (avs_address_i)
            OFS_MSTATE:  nxt_rdata[2:0] = machine_state_reg_ff;
            OFS_MONCTL:  nxt_rdata[1:0] = monitor_control_reg_zero_ff;
            OFS_INSTR_ADDR_BREAKPOINT_REG:    nxt_rdata = instr_addr_breakpoint_reg_ff;
            OFS_STATUS:  nxt_rdata[N_CAUSE-1:0] = status;
            OFS_MASK:    nxt_rdata[N_CAUSE-1:0] = mask;
            OFS_LASTVEC: nxt_rdata[VEC_W-1:0] = last_vec_ff;
            OFS_PEND:    nxt_rdata[N_CAUSE-1:0] = pend_ff;
            OFS_COUNT:   nxt_rdata = taken_cnt_ff;
            default:     nxt_rdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
            rdata_ff <= 32'h0000_0000;
        else if (bus_ff == BUS_IDLE && avs_read_i)
            rdata_ff <= nxt_rdata;
    end

    assign wmerge_ms = be_merge({29'h0, machine_state_reg_ff},
                                avs_writedata_i, avs_byteenable_i);
    assign wmerge_mc = be_merge({30'h0, monitor_control_reg_zero_ff},
                                avs_writedata_i, avs_byteenable_i);
    assign wmerge_bp = be_merge(instr_addr_breakpoint_reg_ff,
                                avs_writedata_i, avs_byteenable_i);
    // Clear and mask writes only act on lanes that are enabled
    assign wmerge_st = be_merge(32'h0000_0000,
                                avs_writedata_i, avs_byteenable_i);
    assign wmerge_mk = be_merge({27'h0, mask},
                                avs_writedata_i, avs_byteenable_i);

    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
            machine_state_reg_ff <= MSTATE_RST;
        else if (wr_commit && avs_address_i == OFS_MSTATE)
            machine_state_reg_ff <= wmerge_ms[2:0];
    end

    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
            monitor_control_reg_zero_ff <= MONCTL_RST;
        else if (wr_commit && avs_address_i == OFS_MONCTL)
            monitor_control_reg_zero_ff <= wmerge_mc[1:0];
    end

    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
            instr_addr_breakpoint_reg_ff <= INSTR_ADDR_BREAKPOINT_REG_RST;
        else if (wr_commit && avs_address_i == OFS_INSTR_ADDR_BREAKPOINT_REG)
            instr_addr_breakpoint_reg_ff <= wmerge_bp;
    end

    evd_irq_ctrl u_irq (
        .core_clk_i  (core_clk_i),
        .rst_i       (rst_i),
        .set_i       (take),
        .wr_status_i (wr_commit && avs_address_i == OFS_STATUS),
        .wr_mask_i   (wr_commit && avs_address_i == OFS_MASK),
        .wdata_i     (avs_address_i == OFS_STATUS ?
                      wmerge_st[N_CAUSE-1:0] : wmerge_mk[N_CAUSE-1:0]),
        .status_o    (status),
        .mask_o      (mask),
        .irq_o       (irq)
    );

    assign avs_readdata_o    = rdata_ff;
    assign avs_waitrequest_o = waitreq_ff;
    assign exc_o             = exc_ff;
    assign irq_o             = irq;

endmodule
`default_nettype wire

// [core/evd_irq_ctrl.sv]
// Sticky status, mask and level interrupt for taken exceptions
`timescale 1ns/1ps
`default_nettype none
module evd_irq_ctrl
    import evd_pkg::*;
(
    // Clock and reset
    input  wire logic               core_clk_i,
    input  wire logic               rst_i,
    // Events
    input  wire logic [N_CAUSE-1:0] set_i,
    // Software access
    input  wire logic               wr_status_i,
    input  wire logic               wr_mask_i,
    input  wire logic [N_CAUSE-1:0] wdata_i,
    // State
    output logic [N_CAUSE-1:0]      status_o,
    output logic [N_CAUSE-1:0]      mask_o,
    output logic                    irq_o
);

    logic [N_CAUSE-1:0] status_ff;
    logic [N_CAUSE-1:0] mask_ff;
    logic               irq_ff;
    logic [N_CAUSE-1:0] nxt_status;

    // Set beats a simultaneous write-one clear
    always_comb
    begin
        nxt_status = status_ff;
        if (wr_status_i)
            nxt_status = nxt_status & ~wdata_i;
        nxt_status = nxt_status | set_i;
    end

    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
            status_ff <= CAUSE_RST;
        else
            status_ff <= nxt_status;
    end

    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
            mask_ff <= CAUSE_RST;
        else if (wr_mask_i)
            mask_ff <= wdata_i;
    end

    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
            irq_ff <= 1'b0;
        else
            irq_ff <= |(status_ff & mask_ff);
    end

    assign status_o = status_ff;
    assign mask_o   = mask_ff;
    assign irq_o    = irq_ff;

endmodule
`default_nettype wire

// [core/evd_pkg.sv]
// Package for the exception vector detect block: constants, types, functions
// Overview of operation
// - A completed system call instruction raises vector 00C00.
// - Trace at 00D00: single-step on any non-rfi success, or branch trace.
// - Floating-point assist vector 00E00 exists but is never generated here.
// - A perf counter turning negative, when enabled, raises vector 00F00.
// - Each perf counter condition has its own enable in monitor control.
// - Perf monitor stays pending while external interrupts are off.
// - Breakpoint at 01300 when address field matches and enable is set.
// - Management interrupt at 01400 while input low and interrupts on.
// - Reserved vector ranges never carry an exception.
package evd_pkg;

    localparam int ADDR_W = 5;
    localparam int VEC_W  = 16;
    localparam int N_CAUSE = 5;

    // Register byte offsets
    localparam logic [ADDR_W-1:0] OFS_MSTATE  = 5'h00;
    localparam logic [ADDR_W-1:0] OFS_MONCTL  = 5'h04;
    localparam logic [ADDR_W-1:0] OFS_INSTR_ADDR_BREAKPOINT_REG    = 5'h08;
    localparam logic [ADDR_W-1:0] OFS_STATUS  = 5'h0C;
    localparam logic [ADDR_W-1:0] OFS_MASK    = 5'h10;
    localparam logic [ADDR_W-1:0] OFS_LASTVEC = 5'h14;
    localparam logic [ADDR_W-1:0] OFS_PEND    = 5'h18;
    localparam logic [ADDR_W-1:0] OFS_COUNT   = 5'h1C;

    // Field positions
    localparam int MS_SE = 0;
    localparam int MS_BE = 1;
    localparam int MS_EE = 2;
    localparam int MC_EN_ONE = 0;
    localparam int MC_EN_TWO = 1;
    localparam int INSTR_ADDR_BREAKPOINT_REG_EN   = 1;
    localparam int INSTR_ADDR_BREAKPOINT_REG_LSB  = 2;
    localparam int CNT_SIGN  = 31;

    // Cause indices, also their fixed priority (0 highest)
    localparam int C_SMI   = 0;
    localparam int C_INSTR_ADDR_BREAKPOINT_REG  = 1;
    localparam int C_SYSC  = 2;
    localparam int C_TRACE = 3;
    localparam int C_PMON  = 4;

    // Reset values
    localparam logic [2:0]  MSTATE_RST = 3'h0;
    localparam logic [1:0]  MONCTL_RST = 2'h0;
    localparam logic [31:0] INSTR_ADDR_BREAKPOINT_REG_RST   = 32'h0000_0000;
    localparam logic [4:0]  CAUSE_RST  = 5'h00;

    // Vector offsets
    localparam logic [VEC_W-1:0] VEC_SYSC   = 16'h0C00;
    localparam logic [VEC_W-1:0] VEC_TRACE  = 16'h0D00;
    localparam logic [VEC_W-1:0] VEC_FPA    = 16'h0E00;
    localparam logic [VEC_W-1:0] VEC_PMON   = 16'h0F00;
    localparam logic [VEC_W-1:0] VEC_INSTR_ADDR_BREAKPOINT_REG   = 16'h1300;
    localparam logic [VEC_W-1:0] VEC_SMI    = 16'h1400;
    localparam logic [VEC_W-1:0] RSV_A_LO   = 16'h0E10;
    localparam logic [VEC_W-1:0] RSV_A_HI   = 16'h0EFF;
    localparam logic [VEC_W-1:0] RSV_B_LO   = 16'h1000;
    localparam logic [VEC_W-1:0] RSV_B_HI   = 16'h12FF;
    localparam logic [VEC_W-1:0] RSV_C_LO   = 16'h1500;
    localparam logic [VEC_W-1:0] RSV_C_HI   = 16'h2FFF;

    typedef enum logic [0:0] {
        BUS_IDLE = 1'b0,
        BUS_ACK  = 1'b1
    } evd_bus_state_t;

    typedef struct packed {
        logic        valid;
        logic        syscall;
        logic        rfi;
        logic        branch;
        logic        ok;
        logic [31:0] addr;
    } evd_cmpl_t;

    typedef struct packed {
        logic             valid;
        logic [VEC_W-1:0] vector;
        logic [4:0]       cause;
    } evd_exc_t;

    function automatic logic [VEC_W-1:0] vec_of_cause(input int idx);
        logic [VEC_W-1:0] v;
        v = VEC_PMON;
        case (idx)
            C_SMI:   v = VEC_SMI;
            C_INSTR_ADDR_BREAKPOINT_REG:  v = VEC_INSTR_ADDR_BREAKPOINT_REG;
            C_SYSC:  v = VEC_SYSC;
            C_TRACE: v = VEC_TRACE;
            default: v = VEC_PMON;
        endcase
        return v;
    endfunction

    function automatic logic vec_is_reserved(input logic [VEC_W-1:0] v);
        return (v >= RSV_A_LO && v <= RSV_A_HI) ||
               (v >= RSV_B_LO && v <= RSV_B_HI) ||
               (v >= RSV_C_LO && v <= RSV_C_HI);
    endfunction

    function automatic logic [31:0] be_merge(input logic [31:0] old,
                                             input logic [31:0] wd,
                                             input logic [3:0]  be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
        begin
            if (be[i])
                r[8*i +: 8] = wd[8*i +: 8];
        end
        return r;
    endfunction

endpackage

// [core/evd_prio_pick.sv]
// Fixed-priority selection of one eligible exception cause
`timescale 1ns/1ps
`default_nettype none
module evd_prio_pick
    import evd_pkg::*;
(
    // Candidates
    input  wire logic [N_CAUSE-1:0] elig_i,
    // Selection
    output logic                    valid_o,
    output logic [N_CAUSE-1:0]      onehot_o,
    output logic [VEC_W-1:0]        vector_o
);

    logic [VEC_W-1:0] cand;

    always_comb
    begin
        valid_o  = 1'b0;
        onehot_o = '0;
        cand     = '0;
        // Lowest index wins; others stay pending for later cycles
        for (int i = N_CAUSE - 1; i >= 0; i--)
        begin
            if (elig_i[i])
            begin
                onehot_o = '0;
                onehot_o[i] = 1'b1;
                cand = vec_of_cause(i);
            end
        end
        // Guard: a reserved vector is never issued
        valid_o  = |elig_i && !vec_is_reserved(cand);
        vector_o = cand;
        if (!valid_o)
            onehot_o = '0;
    end

endmodule
`default_nettype wire

// [dv/evd_cmpl_model.sv]
// Completion stage model that feeds the exception detect block
`timescale 1ns/1ps
`default_nettype none
module evd_cmpl_model
    import evd_pkg::*;
(
    // Clock
    input  wire logic      core_clk_i,
    // Toward the block
    output var  evd_cmpl_t cmpl_o,
    output var  logic      smi_n_o
);
    initial
    begin
        cmpl_o  = '0;
        smi_n_o = 1'b1;
    end

    // One instruction completes at the next edge only
    task automatic complete(input logic sc, input logic rfi, input logic br,
                            input logic ok, input logic [31:0] a);
        cmpl_o <= '{1'b1, sc, rfi, br, ok, a};
        @(posedge core_clk_i);
        // Idle address inverted so the breakpoint cannot match a stale address
        cmpl_o <= '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, ~a};
    endtask

    task automatic system_mgmt_interrupt_in(input logic on);
        smi_n_o <= ~on;
    endtask
endmodule
`default_nettype wire

// [dv/evd_exc_detect_checker.sv]
// Concurrent assertions on the exception detect block ports
`timescale 1ns/1ps
`default_nettype none
module evd_exc_detect_checker
    import evd_pkg::*;
(
    // Clock and reset
    input  wire logic      core_clk_i,
    input  wire logic      rst_i,
    // Core side
    input  wire evd_cmpl_t cmpl_i,
    input  wire logic      system_mgmt_interrupt_n_i,
    input  wire evd_exc_t  exc_o,
    // Bus handshake
    input  wire logic      avs_read_i,
    input  wire logic      avs_write_i,
    input  wire logic      avs_waitrequest_o
);
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (rst_i);

    a_sysc_taken: assert property (cmpl_i.valid && cmpl_i.syscall
        |-> ##[1:4] exc_o.valid && exc_o.cause[C_SYSC])
        else $error("no syscall");
    a_sysc_vec: assert property (exc_o.valid
        && exc_o.cause[C_SYSC] |-> exc_o.vector == 16'h0C00)
        else $error("syscall vector");
    a_trace_vec: assert property (exc_o.valid
        && exc_o.cause[C_TRACE] |-> exc_o.vector == 16'h0D00)
        else $error("trace vector");
    a_pmon_vec: assert property (exc_o.valid
        && exc_o.cause[C_PMON] |-> exc_o.vector == 16'h0F00)
        else $error("monitor vector");
    a_brk_vec: assert property (exc_o.valid
        && exc_o.cause[C_INSTR_ADDR_BREAKPOINT_REG] |-> exc_o.vector == 16'h1300)
        else $error("breakpoint vector");
    a_smi_vec: assert property (exc_o.valid
        && exc_o.cause[C_SMI] |-> exc_o.vector == 16'h1400
        && !$past(system_mgmt_interrupt_n_i))
        else $error("management interrupt");
    a_one_cause: assert property (exc_o.valid
        |-> $onehot(exc_o.cause)) else $error("several causes at once");
    a_no_rsv: assert property (exc_o.valid
        |-> !(exc_o.vector inside {16'h0E00, [16'h0E10:16'h0EFF],
        [16'h1000:16'h12FF], [16'h1500:16'h2FFF]}))
        else $error("reserved vector issued");
    a_bus_wait: assert property ((avs_read_i || avs_write_i)
        && avs_waitrequest_o |=> !avs_waitrequest_o ##1 avs_waitrequest_o)
        else $error("wait cycle");

    c_pmon: cover property (exc_o.valid && exc_o.cause[C_PMON]);
    c_smi: cover property (exc_o.valid && exc_o.cause[C_SMI]);
    c_burst: cover property (exc_o.valid [*3]);
endmodule
`default_nettype wire

// [dv/evd_exc_detect_tb.sv]
// Self-checking testbench for the exception vector detect block
`timescale 1ns/1ps
`default_nettype none
module evd_exc_detect_tb
    import evd_pkg::*;
;
    logic              core_clk_i;
    logic              rst_i;
    evd_cmpl_t         cmpl;
    logic              smi_n;
    logic [31:0]       pc_one;
    logic [31:0]       pc_two;
    logic [ADDR_W-1:0] adr;
    logic              rd_en;
    logic              wr_en;
    logic [31:0]       wdat;
    logic [3:0]        ben;
    logic [31:0]       rdat;
    logic              wait_r;
    evd_exc_t          exc;
    logic              irq;
    int                n_mismatch;
    int                n_checks;
    int                cyc;

    evd_exc_detect i_evd_exc_detect (
        .core_clk_i(core_clk_i), .rst_i(rst_i), .cmpl_i(cmpl),
        .perf_counter_one_i(pc_one), .perf_counter_two_i(pc_two),
        .system_mgmt_interrupt_n_i(smi_n), .avs_address_i(adr),
        .avs_read_i(rd_en), .avs_write_i(wr_en), .avs_writedata_i(wdat),
        .avs_byteenable_i(ben), .avs_readdata_o(rdat),
        .avs_waitrequest_o(wait_r), .exc_o(exc), .irq_o(irq));
    evd_cmpl_model i_evd_cmpl_model (
        .core_clk_i(core_clk_i), .cmpl_o(cmpl), .smi_n_o(smi_n));

    task automatic test_done();
        $display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Holds the request until waitrequest is seen low; one idle edge after
    task automatic bus(input logic w, input logic [4:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        adr   <= a;
        wdat  <= d;
        wr_en <= w;
        rd_en <= ~w;
        do
            @(posedge core_clk_i);
        while (wait_r !== 1'b0);
        q = rdat;
        wr_en <= 1'b0;
        rd_en <= 1'b0;
        @(posedge core_clk_i);
    endtask

    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic rd(input logic [4:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk(q, e);
    endtask

    task automatic exp_exc(input logic [15:0] v, input logic [4:0] c);
        int k;
        k = 0;
        @(posedge core_clk_i);
        while (exc.valid !== 1'b1 && k < 6)
        begin
            @(posedge core_clk_i);
            k++;
        end
        chk({11'h0, exc.cause, exc.vector}, {11'h0, c, v});
    endtask

    task automatic no_exc(input int n);
        repeat (n)
        begin
            @(posedge core_clk_i);
            chk({31'h0, exc.valid}, 32'h0);
        end
    endtask

    task automatic t_regs();
        rd(OFS_MSTATE, 32'h0);
        rd(OFS_MONCTL, 32'h0);
        rd(OFS_INSTR_ADDR_BREAKPOINT_REG, 32'h0);
        rd(OFS_STATUS, 32'h0);
        wr(OFS_COUNT, 32'hFFFF_FFFF);
        rd(OFS_COUNT, 32'h0);
    endtask

    task automatic t_syscall();
        i_evd_cmpl_model.complete(1'b1, 1'b0, 1'b0, 1'b1, 32'h0);
        exp_exc(16'h0C00, 5'h04);
        rd(OFS_STATUS, 32'h4);
        chk({31'h0, irq}, 32'h0);
        wr(OFS_MASK, 32'h4);
        @(posedge core_clk_i);
        chk({31'h0, irq}, 32'h1);
        wr(OFS_STATUS, 32'h4);
        @(posedge core_clk_i);
        chk({31'h0, irq}, 32'h0);
        rd(OFS_LASTVEC, 32'h0C00);
    endtask

    task automatic t_trace();
        wr(OFS_MSTATE, 32'h1);
        i_evd_cmpl_model.complete(1'b0, 1'b0, 1'b0, 1'b1, 32'h40);
        exp_exc(16'h0D00, 5'h08);
        i_evd_cmpl_model.complete(1'b0, 1'b1, 1'b0, 1'b1, 32'h44);
        no_exc(4);
        i_evd_cmpl_model.complete(1'b0, 1'b0, 1'b0, 1'b0, 32'h48);
        no_exc(4);
        wr(OFS_MSTATE, 32'h2);
        i_evd_cmpl_model.complete(1'b0, 1'b0, 1'b1, 1'b1, 32'h4C);
        exp_exc(16'h0D00, 5'h08);
        i_evd_cmpl_model.complete(1'b0, 1'b0, 1'b0, 1'b1, 32'h50);
        no_exc(4);
    endtask

    task automatic t_pmon();
        wr(OFS_MONCTL, 32'h1);
        wr(OFS_MSTATE, 32'h4);
        pc_two <= 32'h8000_0000;
        no_exc(4);
        pc_two <= 32'h0;
        wr(OFS_MSTATE, 32'h0);
        pc_one <= 32'h8000_0000;
        no_exc(4);
        wr(OFS_MSTATE, 32'h4);
        exp_exc(16'h0F00, 5'h10);
        pc_one <= 32'h0;
        wr(OFS_MONCTL, 32'h2);
        pc_two <= 32'h8000_0000;
        exp_exc(16'h0F00, 5'h10);
        pc_two <= 32'h0;
        wr(OFS_MSTATE, 32'h0);
    endtask

    task automatic t_instr_addr_breakpoint_reg();
        wr(OFS_INSTR_ADDR_BREAKPOINT_REG, 32'h0000_1002);
        i_evd_cmpl_model.complete(1'b0, 1'b0, 1'b0, 1'b1, 32'h1000);
        exp_exc(16'h1300, 5'h02);
        i_evd_cmpl_model.complete(1'b0, 1'b0, 1'b0, 1'b1, 32'h1004);
        no_exc(4);
        wr(OFS_INSTR_ADDR_BREAKPOINT_REG, 32'h0000_1000);
        i_evd_cmpl_model.complete(1'b0, 1'b0, 1'b0, 1'b1, 32'h1000);
        no_exc(4);
    endtask

    task automatic t_smi();
        i_evd_cmpl_model.system_mgmt_interrupt_in(1'b1);
        no_exc(4);
        i_evd_cmpl_model.system_mgmt_interrupt_in(1'b0);
        wr(OFS_MSTATE, 32'h4);
        i_evd_cmpl_model.system_mgmt_interrupt_in(1'b1);
        exp_exc(16'h1400, 5'h01);
        i_evd_cmpl_model.system_mgmt_interrupt_in(1'b0);
        wr(OFS_MSTATE, 32'h0);
    endtask

    // Breakpoint, syscall and trace all from one completion
    task automatic t_prio();
        wr(OFS_MSTATE, 32'h1);
        wr(OFS_INSTR_ADDR_BREAKPOINT_REG, 32'h0000_2002);
        i_evd_cmpl_model.complete(1'b1, 1'b0, 1'b0, 1'b1, 32'h2000);
        exp_exc(16'h1300, 5'h02);
        exp_exc(16'h0C00, 5'h04);
        exp_exc(16'h0D00, 5'h08);
        wr(OFS_MSTATE, 32'h0);
        // Ten exceptions taken over the whole run, none left behind
        rd(OFS_COUNT, 32'h0000_000A);
        rd(OFS_PEND, 32'h0);
    endtask

    initial
    begin
        core_clk_i = 1'b0;
        forever
            #4 core_clk_i = ~core_clk_i;
    end

    // Whole run needs well under a thousand cycles
    always @(posedge core_clk_i)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            n_mismatch++;
            test_done();
        end
    end

    initial
    begin
        rst_i = 1'b1;
        {adr, rd_en, wr_en, wdat, pc_one, pc_two} = '0;
        ben = 4'hF;
        n_mismatch = 0;
        n_checks = 0;
        cyc = 0;
        repeat (20) @(posedge core_clk_i);
        rst_i <= 1'b0;
        @(posedge core_clk_i);
        t_regs();
        t_syscall();
        t_trace();
        t_pmon();
        t_instr_addr_breakpoint_reg();
        t_smi();
        t_prio();
        test_done();
    end
endmodule

bind evd_exc_detect evd_exc_detect_checker i_evd_exc_detect_checker (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .cmpl_i(cmpl_i),
    .system_mgmt_interrupt_n_i(system_mgmt_interrupt_n_i), .exc_o(exc_o),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_waitrequest_o(avs_waitrequest_o));
`default_nettype wire
